// file: hw/cdf_cltu_dec.v
// CLTU decoder: channel sync, start search, codeblock decode and frame hand-off
`timescale 1ns/1ns
`default_nettype none
`include "cdf_map.vh"
module cdf_cltu_dec #(
  parameter TMO_CYC = `CDF_TMO_NS / `CDF_CLK_NS
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Telecommand channel
  input wire tc_bit_lock,
  input wire tc_modulation,
  input wire tc_bit_clk,
  input wire tc_data,
  input wire tc_hi_prio_active,
  input wire prio_mode,
  // Expected header values
  input wire [23:0] exp_hdr,
  // Transfer layer stream
  output wire oct_valid,
  input wire oct_ready,
  output wire [7:0] oct_data,
  output wire oct_last_of_block,
  output reg frame_active_ff,
  output reg block_active_ff,
  output reg frame_end_ff,
  output reg frame_erase_ff,
  // Events and status
  output wire cltu_decoding_active,
  output reg cltu_error_event_ff,
  output reg cltu_abandoned_ff,
  output reg reject_event_ff,
  output reg activation_event_ff,
  output reg start_found_ff,
  // Frame results
  output wire [1:0] frame_type,
  output wire [7:0] frame_len,
  output wire [7:0] seq_num,
  output wire hdr_match,
  output wire seq_zero_ok,
  output wire is_unlock,
  output wire is_set_vr,
  output wire [7:0] set_vr_val,
  output wire crc_ok,
  output wire result_valid
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  reg [4:0] s1_ff;
  reg [4:0] s2_ff;
  reg clk_d_ff;
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
      clk_d_ff <= 1'b0;
    end else if (ce) begin
      s1_ff <= {tc_bit_lock, tc_modulation, tc_bit_clk, tc_data, tc_hi_prio_active};
      s2_ff <= s1_ff;
      clk_d_ff <= s2_ff[2];
    end
  end
  wire lock_s = s2_ff[4];
  wire mod_s = s2_ff[3];
  wire data_s = s2_ff[1];
  wire hiprio_s = s2_ff[0] && prio_mode;
  wire bit_stb = s2_ff[2] && !clk_d_ff;
  wire chan_up = lock_s && mod_s;
  wire clk_edge = s2_ff[2] ^ clk_d_ff;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [4:0] popc16;
    input [15:0] v;
    integer k;
    begin
      popc16 = 5'h00;
      for (k = 0; k < 16; k = k + 1) popc16 = popc16 + {4'h0, v[k]};
    end
  endfunction
  // Syndrome of g(x)=x^7+x^6+x^2+1 over 56 info bits; parity sent complemented
  function [6:0] bch_par;
    input [55:0] d;
    integer k;
    reg [6:0] r;
    begin
      r = 7'h00;
      for (k = 55; k >= 0; k = k - 1) begin
        if (r[6] ^ d[k]) r = {r[5:0], 1'b0} ^ 7'h45;
        else r = {r[5:0], 1'b0};
      end
      bch_par = ~r;
    end
  endfunction

  // ----------------------------------------
  // CLTU state machine
  // ----------------------------------------
  localparam [1:0] ST_INACTIVE = `CDF_ST_INACTIVE;
  localparam [1:0] ST_SEARCH = `CDF_ST_SEARCH;
  localparam [1:0] ST_DECODE = `CDF_ST_DECODE;
  reg [1:0] state_ff;
  reg [15:0] shreg_ff;
  reg invert_ff;
  reg [63:0] cb_ff;
  reg [6:0] bitcnt_ff;
  reg [5:0] cbcnt_ff;
  reg [31:0] tmo_ff;
  reg cb_done_ff;
  reg [63:0] blk_ff;
  reg [55:0] info_ff;
  reg [2:0] ocnt_ff;
  reg sending_ff;
  wire [15:0] nxt_sh = {shreg_ff[14:0], data_s};
  wire start_hit = (popc16(nxt_sh ^ `CDF_START_SEQ) <= 5'h01);
  wire start_inv = (popc16(~nxt_sh ^ `CDF_START_SEQ) <= 5'h01);
  wire [6:0] synd = bch_par(blk_ff[63:8]) ^ blk_ff[7:1];
  wire par_odd = ^synd;
  reg [55:0] corr_info;
  reg corr_hit;
  integer j;
  // Single-error search by trial; combinational cost traded for no lookup table
  always @* begin
    corr_info = blk_ff[63:8];
    corr_hit = 1'b0;
    for (j = 0; j < 56; j = j + 1) begin
      if (!corr_hit && bch_par(blk_ff[63:8] ^ ({55'h0, 1'b1} << j)) == blk_ff[7:1]) begin
        corr_info = blk_ff[63:8] ^ ({55'h0, 1'b1} << j);
        corr_hit = 1'b1;
      end
    end
  end
  wire single_par = (popc16({9'h000, synd ^ bch_par(blk_ff[63:8])}) != 5'h00) && !corr_hit && par_odd;
  wire cb_good = (synd == 7'h00);
  wire cb_corr = !cb_good && (corr_hit || single_par) && !blk_ff[0];
  wire cb_reject = !cb_good && !cb_corr;
  wire buf_in_ready;
  wire tmo = (tmo_ff == TMO_CYC);

  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_INACTIVE;
      shreg_ff <= 16'h0000;
      invert_ff <= 1'b0;
      cb_ff <= 64'h0;
      bitcnt_ff <= 7'h00;
      cbcnt_ff <= 6'h00;
      tmo_ff <= 32'h0;
      cb_done_ff <= 1'b0;
      blk_ff <= 64'h0;
      info_ff <= 56'h0;
      ocnt_ff <= 3'h0;
      sending_ff <= 1'b0;
      frame_active_ff <= 1'b0;
      block_active_ff <= 1'b0;
      frame_end_ff <= 1'b0;
      frame_erase_ff <= 1'b0;
      cltu_error_event_ff <= 1'b0;
      cltu_abandoned_ff <= 1'b0;
      reject_event_ff <= 1'b0;
      activation_event_ff <= 1'b0;
      start_found_ff <= 1'b0;
    end else if (ce) begin
      frame_end_ff <= 1'b0;
      frame_erase_ff <= 1'b0;
      cltu_error_event_ff <= 1'b0;
      cltu_abandoned_ff <= 1'b0;
      reject_event_ff <= 1'b0;
      activation_event_ff <= 1'b0;
      start_found_ff <= 1'b0;
      if (clk_edge || state_ff != ST_DECODE) tmo_ff <= 32'h0;
      else if (!tmo) tmo_ff <= tmo_ff + 32'h1;
      // Octet drain of the current block
      if (sending_ff && buf_in_ready) begin
        info_ff <= {info_ff[47:0], 8'h00};
        ocnt_ff <= ocnt_ff + 3'h1;
        if (ocnt_ff == 3'h6) begin
          sending_ff <= 1'b0;
          block_active_ff <= 1'b0;
        end
      end
      case (state_ff)
        ST_INACTIVE: begin
          if (chan_up) begin
            state_ff <= ST_SEARCH;
            activation_event_ff <= 1'b1;
          end
        end
        ST_SEARCH: begin
          if (!chan_up) state_ff <= ST_INACTIVE;
          else if (bit_stb) begin
            shreg_ff <= nxt_sh;
            if (start_hit || start_inv) begin
              state_ff <= ST_DECODE;
              invert_ff <= !start_hit;
              start_found_ff <= 1'b1;
              bitcnt_ff <= 7'h00;
              cbcnt_ff <= 6'h00;
              cb_done_ff <= 1'b0;
            end
          end
        end
        ST_DECODE: begin
          if (!chan_up) begin
            state_ff <= ST_INACTIVE;
            cltu_abandoned_ff <= 1'b1;
            frame_erase_ff <= frame_active_ff;
            frame_active_ff <= 1'b0;
            sending_ff <= 1'b0;
            block_active_ff <= 1'b0;
            cb_done_ff <= 1'b0;
          end else if (tmo || hiprio_s) begin
            state_ff <= ST_SEARCH;
            cltu_error_event_ff <= 1'b1;
            cltu_abandoned_ff <= 1'b1;
            frame_erase_ff <= frame_active_ff;
            frame_active_ff <= 1'b0;
            sending_ff <= 1'b0;
            block_active_ff <= 1'b0;
            cb_done_ff <= 1'b0;
            shreg_ff <= 16'h0000;
          end else begin
            // A finished block waits for the previous one to drain; if it still waits when the next block completes, blk_ff is overwritten and its octets are lost
            if (cb_done_ff && !sending_ff) begin
              cb_done_ff <= 1'b0;
              if (cb_reject) begin
                state_ff <= ST_SEARCH;
                reject_event_ff <= 1'b1;
                frame_end_ff <= frame_active_ff;
                cltu_abandoned_ff <= !frame_active_ff;
                frame_active_ff <= 1'b0;
                shreg_ff <= 16'h0000;
              end else if (cbcnt_ff == `CDF_MAX_CB) begin
                state_ff <= ST_SEARCH;
                cltu_error_event_ff <= 1'b1;
                cltu_abandoned_ff <= 1'b1;
                frame_erase_ff <= 1'b1;
                frame_active_ff <= 1'b0;
                shreg_ff <= 16'h0000;
              end else begin
                cbcnt_ff <= cbcnt_ff + 6'h01;
                info_ff <= cb_good ? blk_ff[63:8] : corr_info;
                ocnt_ff <= 3'h0;
                sending_ff <= 1'b1;
                block_active_ff <= 1'b1;
                frame_active_ff <= 1'b1;
              end
            end
            // Bits keep arriving while a decision waits; the finished block is held in its own register
            if (bit_stb) begin
              cb_ff <= {cb_ff[62:0], data_s ^ invert_ff};
              if (bitcnt_ff == `CDF_CB_BITS - 7'h01) begin
                bitcnt_ff <= 7'h00;
                cb_done_ff <= 1'b1;
                blk_ff <= {cb_ff[62:0], data_s ^ invert_ff};
              end else bitcnt_ff <= bitcnt_ff + 7'h01;
            end
          end
        end
        default: state_ff <= ST_INACTIVE;
      endcase
    end
  end
  assign cltu_decoding_active = (state_ff == ST_DECODE);

  // ----------------------------------------
  // Output buffer and frame checker
  // ----------------------------------------
  wire [8:0] buf_out;
  cdf_buf2 u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(sending_ff),
    .in_ready(buf_in_ready),
    .in_data({ocnt_ff == 3'h6, info_ff[55:48]}),
    .out_valid(oct_valid),
    .out_ready(oct_ready),
    .out_data(buf_out)
  );
  assign oct_data = buf_out[7:0];
  assign oct_last_of_block = buf_out[8];
  cdf_frame_chk u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .frm_start(start_found_ff || frame_erase_ff),
    .oct_valid(oct_valid && oct_ready),
    .oct_data(oct_data),
    .frm_end(frame_end_ff),
    .exp_hdr(exp_hdr),
    .frame_type_ff(frame_type),
    .frame_len_ff(frame_len),
    .seq_num_ff(seq_num),
    .hdr_match_ff(hdr_match),
    .seq_zero_ok_ff(seq_zero_ok),
    .is_unlock_ff(is_unlock),
    .is_set_vr_ff(is_set_vr),
    .set_vr_val_ff(set_vr_val),
    .crc_ok_ff(crc_ok),
    .result_valid_ff(result_valid)
  );
endmodule // cdf_cltu_dec
`default_nettype wire

// file: hw/cdf_map.vh
// Constants for the CLTU decoder and frame parser
`ifndef CDF_MAP_VH
`define CDF_MAP_VH
`define CDF_ST_INACTIVE 2'h0
`define CDF_ST_SEARCH 2'h1
`define CDF_ST_DECODE 2'h2
`define CDF_START_SEQ 16'heb90
`define CDF_MAX_CB 6'h25
`define CDF_CB_BITS 7'h40
`define CDF_INFO_OCTETS 3'h7
`define CDF_HDR_OCTETS 8'h05
`define CDF_MAX_DATA 8'hf9
`define CDF_CRC_PRESET 16'hffff
`define CDF_CRC_POLY 16'h1021
`define CDF_CRC_GOOD 16'h0000
`define CDF_FT_AD 2'h0
`define CDF_FT_ILL 2'h1
`define CDF_FT_BD 2'h2
`define CDF_FT_BC 2'h3
`define CDF_CMD_UNLOCK 8'h00
`define CDF_CMD_SETVR 8'h82
`define CDF_TMO_NS 983000000
`define CDF_CLK_NS 20
`endif

// file: hw/cdf_buf2.v
// Two-entry buffer between the decoder and the transfer layer
`timescale 1ns/1ns
`default_nettype none
module cdf_buf2 (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [8:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [8:0] out_data
);
  reg [8:0] mem_ff [0:1];
  reg wp_ff;
  reg rp_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (!rst_n) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= 9'h000;
      mem_ff[1] <= 9'h000;
    end else if (ce) begin
      if (push) begin
        mem_ff[wp_ff] <= in_data;
        wp_ff <= ~wp_ff;
      end
      if (pop) rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // cdf_buf2
`default_nettype wire

// file: hw/cdf_frame_chk.v
// Transfer frame header decode, command recognition and CRC check
`timescale 1ns/1ns
`default_nettype none
`include "cdf_map.vh"
module cdf_frame_chk (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Octet stream
  input wire frm_start,
  input wire oct_valid,
  input wire [7:0] oct_data,
  input wire frm_end,
  // Expected header
  input wire [23:0] exp_hdr,
  // Results
  output reg [1:0] frame_type_ff,
  output reg [7:0] frame_len_ff,
  output reg [7:0] seq_num_ff,
  output reg hdr_match_ff,
  output reg seq_zero_ok_ff,
  output reg is_unlock_ff,
  output reg is_set_vr_ff,
  output reg [7:0] set_vr_val_ff,
  output reg crc_ok_ff,
  output reg result_valid_ff
);
  reg [15:0] crc_ff;
  reg [7:0] cnt_ff;
  reg [23:0] hdr_ff;
  reg [7:0] d0_ff;
  reg [7:0] d1_ff;
  reg [7:0] d2_ff;
  reg [15:0] nxt_crc;
  integer i;
  wire [7:0] data_len;
  wire [7:0] real_len;
  // CRC over every octet, msb first
  always @* begin
    nxt_crc = crc_ff;
    for (i = 7; i >= 0; i = i - 1) begin
      if (nxt_crc[15] ^ oct_data[i]) nxt_crc = {nxt_crc[14:0], 1'b0} ^ `CDF_CRC_POLY;
      else nxt_crc = {nxt_crc[14:0], 1'b0};
    end
  end
  // Data field is total octets less header and CRC: length field plus one, less seven
  assign data_len = frame_len_ff - 8'h06;
  assign real_len = cnt_ff - 8'h01;
  always @(posedge clk) begin
    if (!rst_n) begin
      crc_ff <= `CDF_CRC_PRESET;
      cnt_ff <= 8'h00;
      hdr_ff <= 24'h000000;
      d0_ff <= 8'h00;
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
      frame_type_ff <= `CDF_FT_AD;
      frame_len_ff <= 8'h00;
      seq_num_ff <= 8'h00;
      hdr_match_ff <= 1'b0;
      seq_zero_ok_ff <= 1'b0;
      is_unlock_ff <= 1'b0;
      is_set_vr_ff <= 1'b0;
      set_vr_val_ff <= 8'h00;
      crc_ok_ff <= 1'b0;
      result_valid_ff <= 1'b0;
    end else if (ce) begin
      result_valid_ff <= 1'b0;
      if (frm_start) begin
        crc_ff <= `CDF_CRC_PRESET;
        cnt_ff <= 8'h00;
      end else if (oct_valid) begin
        crc_ff <= nxt_crc;
        if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
        case (cnt_ff)
          8'h00: hdr_ff[23:16] <= oct_data;
          8'h01: hdr_ff[15:8] <= oct_data;
          8'h02: hdr_ff[7:0] <= oct_data;
          8'h03: frame_len_ff <= oct_data;
          8'h04: seq_num_ff <= oct_data;
          8'h05: d0_ff <= oct_data;
          8'h06: d1_ff <= oct_data;
          8'h07: d2_ff <= oct_data;
          default: ;
        endcase
      end
      if (frm_end) begin
        result_valid_ff <= 1'b1;
        frame_type_ff <= hdr_ff[21:20];
        // Flags masked out of the comparison; version and reserved fields expected 00
        hdr_match_ff <= ({hdr_ff[23:22], hdr_ff[19:0]} == {exp_hdr[23:22], exp_hdr[19:0]}) &&
          (hdr_ff[23:22] == 2'h0) && (hdr_ff[19:18] == 2'h0) && (hdr_ff[1:0] == 2'h0);
        seq_zero_ok_ff <= (hdr_ff[21:20] == `CDF_FT_AD) || (seq_num_ff == 8'h00);
        is_unlock_ff <= (hdr_ff[21:20] == `CDF_FT_BC) && (data_len == 8'h01) &&
          (d0_ff == `CDF_CMD_UNLOCK);
        is_set_vr_ff <= (hdr_ff[21:20] == `CDF_FT_BC) && (data_len == 8'h03) &&
          (d0_ff == `CDF_CMD_SETVR) && (d1_ff == 8'h00);
        set_vr_val_ff <= d2_ff;
        // Length consistency is judged here too: CRC is good only if octet count less one equals the length field
        crc_ok_ff <= (crc_ff == `CDF_CRC_GOOD) && (real_len == frame_len_ff);
      end
    end
  end
endmodule // cdf_frame_chk
`default_nettype wire

// file: test/cdf_cltu_asserts.sv
// Port-level checks on the CLTU decoder
`timescale 1ns/1ns
`default_nettype none
module cdf_cltu_asserts #(
  parameter TMO_CYC = 2000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel
  input wire logic tc_bit_lock,
  input wire logic tc_bit_clk,
  // Stream
  input wire logic oct_valid,
  input wire logic oct_ready,
  input wire logic [7:0] oct_data,
  input wire logic frame_active_ff,
  input wire logic block_active_ff,
  input wire logic frame_end_ff,
  // Events
  input wire logic cltu_decoding_active,
  input wire logic cltu_error_event_ff,
  input wire logic cltu_abandoned_ff,
  input wire logic reject_event_ff,
  input wire logic start_found_ff,
  input wire logic result_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Bit clock idle counter
  // ----------------------------------------
  logic [31:0] idle_ff;
  logic bclk_q_ff;
  always_ff @(posedge clk) begin
    bclk_q_ff <= tc_bit_clk;
    if (!rst_n || bclk_q_ff != tc_bit_clk) idle_ff <= 32'h0;
    else if (idle_ff != 32'hffffffff) idle_ff <= idle_ff + 32'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_close; reject_event_ff ##1 result_valid; endsequence
  sequence s_abandon; ##[0:2] cltu_abandoned_ff; endsequence
  AST_IDLE_NO_LOCK: assert property (!tc_bit_lock [*6] |-> !cltu_decoding_active)
    else $error("decoding without bit lock");
  AST_DEC_ENTRY: assert property ($rose(cltu_decoding_active) |-> start_found_ff || $past(start_found_ff))
    else $error("decode entered without start pattern");
  AST_REJ_LEAVES: assert property (reject_event_ff |-> ##[0:2] !cltu_decoding_active)
    else $error("decode kept after rejection");
  AST_END_ON_REJ: assert property (frame_end_ff |-> s_close)
    else $error("frame end without rejection and result");
  AST_ERR_ABANDON: assert property (cltu_error_event_ff |-> s_abandon)
    else $error("error not reported as abandoned");
  AST_BLOCK_IN_FRAME: assert property (block_active_ff |-> frame_active_ff)
    else $error("block indication outside frame");
  AST_OCT_HOLD: assert property (oct_valid && !oct_ready |=> oct_valid && $stable(oct_data))
    else $error("octet lost under stall");
  AST_CLK_TIMEOUT: assert property (cltu_decoding_active |-> idle_ff <= TMO_CYC + 16)
    else $error("bit clock timeout missed");
endmodule // cdf_cltu_asserts
bind cdf_cltu_dec cdf_cltu_asserts #(.TMO_CYC(TMO_CYC)) cdf_cltu_asserts_i (.clk, .rst_n, .tc_bit_lock,
  .tc_bit_clk, .oct_valid, .oct_ready, .oct_data, .frame_active_ff, .block_active_ff, .frame_end_ff,
  .cltu_decoding_active, .cltu_error_event_ff, .cltu_abandoned_ff, .reject_event_ff, .start_found_ff,
  .result_valid);
`default_nettype wire

// file: test/cdf_tl_model.sv
// Transfer layer model: slow, stallable octet sink
`timescale 1ns/1ns
`default_nettype none
module cdf_tl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic stall,
  input wire logic clr,
  // Octet stream
  input wire logic oct_valid,
  output logic oct_ready,
  input wire logic [7:0] oct_data,
  input wire logic oct_last_of_block,
  // Received octets
  output logic [7:0] rx_ff [0:63],
  output logic [8:0] rx_n_ff,
  output logic [8:0] bad_n_ff
);
  logic rdy_ff;
  assign oct_ready = rdy_ff;
  // Ready at most every other cycle, so the two-entry buffer backs up
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      rdy_ff <= 1'b0;
      rx_n_ff <= 9'h000;
      bad_n_ff <= 9'h000;
    end else begin
      rdy_ff <= !stall && !rdy_ff;
      if (oct_valid && rdy_ff) begin
        if (rx_n_ff < 9'h040) rx_ff[rx_n_ff[5:0]] <= oct_data;
        rx_n_ff <= rx_n_ff + 9'h001;
        if (oct_last_of_block !== (rx_n_ff % 9'h007 == 9'h006)) bad_n_ff <= bad_n_ff + 9'h001;
      end
    end
  end
endmodule // cdf_tl_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the CLTU decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g)!==(e)) begin n_fail++; $display("unexpected %0t %s", $time, m); end end
module tb_top;
  localparam int TMO = 2000;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, tc_bit_lock = 1'b0, tc_modulation = 1'b0, tc_bit_clk = 1'b1;
  logic tc_data = 1'b0, tc_hi_prio_active = 1'b0, prio_mode = 1'b0, stall = 1'b0, clr = 1'b0;
  logic [23:0] exp_hdr = 24'h02a54c;
  wire oct_valid, oct_ready, oct_last_of_block, frame_active_ff, block_active_ff, frame_end_ff, frame_erase_ff;
  wire cltu_decoding_active, cltu_error_event_ff, cltu_abandoned_ff, reject_event_ff, activation_event_ff;
  wire start_found_ff, hdr_match, seq_zero_ok, is_unlock, is_set_vr, crc_ok, result_valid;
  wire [7:0] oct_data, frame_len, seq_num, set_vr_val;
  wire [1:0] frame_type;
  wire [7:0] rx [0:63];
  wire [8:0] rx_n, bad_n;
  logic [7:0] fr [0:13];
  int n_fail = 0, cmp_count = 0, ev[8] = '{8{0}}, ev0[8];
  always #10 clk = ~clk;
  cdf_cltu_dec #(.TMO_CYC(TMO)) cdf_cltu_dec_i (.clk, .rst_n, .ce, .tc_bit_lock, .tc_modulation, .tc_bit_clk,
    .tc_data, .tc_hi_prio_active, .prio_mode, .exp_hdr, .oct_valid, .oct_ready, .oct_data, .oct_last_of_block,
    .frame_active_ff, .block_active_ff, .frame_end_ff, .frame_erase_ff, .cltu_decoding_active,
    .cltu_error_event_ff, .cltu_abandoned_ff, .reject_event_ff, .activation_event_ff, .start_found_ff,
    .frame_type, .frame_len, .seq_num, .hdr_match, .seq_zero_ok, .is_unlock, .is_set_vr, .set_vr_val, .crc_ok,
    .result_valid);
  cdf_tl_model cdf_tl_model_i (.clk, .rst_n, .stall, .clr, .oct_valid, .oct_ready, .oct_data,
    .oct_last_of_block, .rx_ff(rx), .rx_n_ff(rx_n), .bad_n_ff(bad_n));
  // ----------------------------------------
  // Event counting and helpers
  // ----------------------------------------
  wire [7:0] evs = {result_valid, cltu_abandoned_ff, cltu_error_event_ff, frame_erase_ff, frame_end_ff,
    reject_event_ff, start_found_ff, activation_event_ff};
  always @(posedge clk) for (int i = 0; i < 8; i++) if (evs[i] === 1'b1) ev[i]++;
  function automatic int d(input int i);
    return ev[i] - ev0[i];
  endfunction
  // Snapshot away from the clock edge so the counting process never races it
  task automatic snap();
    @(negedge clk);
    ev0 = ev;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic sbit(input logic b);
    tc_data <= b;
    tc_bit_clk <= 1'b0;
    repeat (4) @(posedge clk);
    tc_bit_clk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic sword(input logic [63:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) sbit(w[i]);
  endtask
  // Three idle bits, then the start pattern with one bit wrong
  task automatic start_seq();
    sword({48'h0, 16'heb90 ^ 16'h0400}, 19);
  endtask
  function automatic logic [63:0] cb(input logic [55:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 55; i >= 0; i--) r = {r[5:0], 1'b0} ^ ((v[i] ^ r[6]) ? 7'h45 : 7'h00);
    return {v, ~r, 1'b0};
  endfunction
  function automatic logic [63:0] blk(input int k);
    return cb({fr[7*k], fr[7*k+1], fr[7*k+2], fr[7*k+3], fr[7*k+4], fr[7*k+5], fr[7*k+6]});
  endfunction
  function automatic logic [15:0] crc16(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++)
      for (int j = 7; j >= 0; j--) c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[i][j]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // Frame padded with zero octets to two codeblocks
  task automatic build(input logic [1:0] f, input logic [7:0] sq, input int dl, input int cmd, input logic hb);
    logic [15:0] c;
    fr = '{default: 8'h00};
    fr[0] = {2'b00, f, 4'h2};
    fr[1] = 8'ha5;
    fr[2] = hb ? 8'h48 : 8'h4c;
    fr[3] = 8'(6 + dl);
    fr[4] = sq;
    for (int i = 0; i < dl; i++) fr[5 + i] = 8'h30 + 8'(i);
    if (cmd == 1) {fr[5], fr[6], fr[7]} = 24'h82005a;
    if (cmd == 2) fr[5] = 8'h00;
    c = crc16(5 + dl);
    {fr[5 + dl], fr[6 + dl]} = c;
  endtask
  task automatic wait_ev(input int i, input int lim);
    for (int n = 0; n < lim && d(i) == 0; n++) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle();
    build(2'h0, 8'h00, 7, 0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      snap();
      tc_bit_lock <= k[0];
      tc_modulation <= !k[0];
      start_seq();
      sword(blk(0), 64);
      `CHK(d(0) + d(1), 0, "activity without lock")
      `CHK(cltu_decoding_active, 1'b0, "decode while idle")
    end
    snap();
    tc_bit_lock <= 1'b1;
    tc_modulation <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(d(0), 1, "no activation")
    $display("test idle done");
  endtask
  task automatic t_frames();
    logic [1:0] fl [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    int dl [5] = '{7, 7, 7, 3, 1};
    for (int v = 0; v < 5; v++) begin
      build(fl[v], (v == 0) ? 8'h3c : 8'h00, dl[v], v - 2, v == 2);
      if (v == 1) fr[12] = fr[12] ^ 8'h01;
      snap();
      start_seq();
      sword(blk(0) ^ (64'h1 << 40), 64);
      stall <= (v == 0);
      `CHK(cltu_decoding_active, 1'b1, "not decoding")
      sword(blk(1), 64);
      stall <= 1'b0;
      sword(64'h5555555555555555, 64);
      wait_ev(7, 300);
      repeat (80) @(posedge clk);
      `CHK(d(1), 1, "start pattern missed")
      `CHK(d(2) + 10 * d(3) + 100 * d(4), 11, "frame close")
      `CHK(rx_n, 9'h00e, "octet count")
      `CHK(bad_n, 9'h000, "block marker")
      for (int i = 0; i < 14; i++) `CHK(rx[i], fr[i], "octet value")
      `CHK(frame_type, fl[v], "frame type")
      `CHK(frame_len, 8'(6 + dl[v]), "length field")
      `CHK(seq_num, fr[4], "sequence field")
      `CHK(hdr_match, v != 2, "header compare")
      if (v > 1) `CHK(seq_zero_ok, 1'b1, "zero sequence")
      if (v < 3) `CHK(crc_ok, v != 1, "crc result")
      `CHK(is_set_vr, v == 3, "set counter command")
      if (v == 3) `CHK(set_vr_val, 8'h5a, "counter value")
      `CHK(is_unlock, v == 4, "unlock command")
      `CHK(cltu_decoding_active, 1'b0, "still decoding")
    end
    $display("test frames done");
  endtask
  task automatic t_rej();
    logic [63:0] w [3];
    w[0] = 64'h5555555555555555;
    w[1] = blk(0) ^ (64'h3 << 20);
    w[2] = blk(0) ^ (64'h1 << 40) ^ 64'h1;
    for (int k = 0; k < 3; k++) begin
      snap();
      start_seq();
      sword(w[k], 64);
      repeat (60) @(posedge clk);
      `CHK(d(2), 1, "no rejection")
      `CHK(d(3) + d(7), 0, "frame handed over")
      `CHK(rx_n, 9'h000, "octets of rejected block")
      `CHK(cltu_decoding_active, 1'b0, "decode after rejection")
    end
    $display("test reject done");
  endtask
  // Deactivation, bit clock timeout, higher priority, 38 codeblocks with only 37 accepted
  task automatic t_abort();
    for (int k = 0; k < 4; k++) begin
      snap();
      start_seq();
      for (int b = 0; b < ((k == 3) ? 38 : 1); b++) sword(blk(0), 64);
      if (k == 0) tc_bit_lock <= 1'b0;
      if (k == 2) {prio_mode, tc_hi_prio_active} <= 2'b11;
      wait_ev(4, TMO + 500);
      repeat (10) @(posedge clk);
      `CHK(d(4) + d(6), 2, "frame not erased")
      `CHK(d(5), k != 0, "error event")
      `CHK(d(3), 0, "frame ended normally")
      `CHK(cltu_decoding_active, 1'b0, "still decoding")
      {prio_mode, tc_hi_prio_active, tc_bit_lock} <= 3'b001;
      repeat (20) @(posedge clk);
    end
    $display("test abort done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_idle();
    t_frames();
    t_rej();
    t_abort();
    end_sim();
  end
  // Tests need about 40000 cycles
  initial begin
    #2000000;
    n_fail++;
    $display("unexpected %0t watchdog", $time);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
